/* logic/drive_timing_pkg.sv */
// drive timing selection: shared constants and carrier types
// assumes one 100 MHz pci clock domain and a configuration write port
package drive_timing_pkg;
  // configuration space offsets; the master register placement is our own choice
  localparam logic [7:0] SLAVE_TIMING_OFS = 8'h44;
  localparam logic [7:0] MASTER_TIMING_OFS = 8'h40;
  localparam logic [7:0] SLAVE_TIMING_RST = 8'h00;
  localparam logic [15:0] MASTER_TIMING_RST = 16'h0000;
  // master register field positions
  localparam int FAST_SEL_DRV0_BIT = 0;
  localparam int READY_EN_DRV0_BIT = 1;
  localparam int PREFETCH_DRV0_BIT = 2;
  localparam int DMA_ONLY_DRV0_BIT = 3;
  localparam int FAST_SEL_DRV1_BIT = 4;
  localparam int READY_EN_DRV1_BIT = 5;
  localparam int PREFETCH_DRV1_BIT = 6;
  localparam int DMA_ONLY_DRV1_BIT = 7;
  localparam int MASTER_RECOV_LSB = 8;
  localparam int MASTER_SAMPLE_LSB = 12;
  localparam int SLAVE_REG_EN_BIT = 14;
  // slave register field positions
  localparam int SLAVE_RECOV_LSB = 4;
  localparam int SLAVE_SAMPLE_LSB = 6;
  // drive-select bit inside the device/head register
  localparam int DRIVE_SEL_BIT = 4;
  // base clock counts: encoding 00 gives the largest count
  localparam logic [2:0] SAMPLE_BASE_CLKS = 3'h5;
  localparam logic [2:0] RECOV_BASE_CLKS = 3'h4;

  typedef enum logic [1:0] {
    PATH_COMPAT16 = 2'h0,
    PATH_COMPAT8 = 2'h1,
    PATH_FAST = 2'h2
  } timing_path_t;

  // one access into the enabled io range
  typedef struct packed {
    logic valid;
    logic data_port;
    logic dma;
    logic is_write;
  } access_req_t;

  // decision handed to the strobe engine
  typedef struct packed {
    timing_path_t path;
    logic sample_ready;
    logic prefetch_post;
    logic [2:0] sample_clks;
    logic [2:0] recov_clks;
  } timing_sel_t;
endpackage

/* logic/ide_drive_timing_select.sv */
// per-drive timing selection for one ide channel (secondary channel)
// assumes config writes and io accesses are synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none

module ide_drive_timing_select
  import drive_timing_pkg::*;
(
  // clock and asynchronous reset
  input wire logic sys_clk,
  input wire logic rst,
  // configuration register port
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  input wire logic [1:0] cfg_be,
  output logic [15:0] cfg_rdata,
  // snooped device/head register write
  input wire logic io_wr_drive_head,
  input wire logic [7:0] io_wdata,
  // access qualifiers and cable ready level
  input wire access_req_t acc,
  input wire logic ready_pin,
  // timing decision for the strobe engine
  output timing_sel_t sel,
  output logic ready_int,
  output logic drive_sel
);

  // whole module state
  typedef struct packed {
    logic [15:0] master_q;
    logic [7:0] slave_q;
    logic drive_q;
    timing_sel_t sel_q;
  } state_t;

  state_t s_q, s_d;

  // encoding 00 gives the base count, each step one clock less
  function automatic logic [2:0] enc_clks(input logic [2:0] base, input logic [1:0] code);
    enc_clks = base - {1'b0, code};
  endfunction

  // working values for the decision
  logic fast_sel, dma_only, ready_en, pf_en, use_slave;
  logic [1:0] sp_code, rc_code;

  // next-state logic
  always_comb begin
    s_d = s_q;
    // configuration writes, byte enabled
    if (cfg_wr && cfg_addr == MASTER_TIMING_OFS) begin
      if (cfg_be[0]) begin
        s_d.master_q[7:0] = cfg_wdata[7:0];
      end
      if (cfg_be[1]) begin
        s_d.master_q[15:8] = cfg_wdata[15:8];
      end
    end
    if (cfg_wr && cfg_addr == SLAVE_TIMING_OFS && cfg_be[0]) begin
      s_d.slave_q = cfg_wdata[7:0];
    end
    // snoop the drive-select copy from the device/head register
    if (io_wr_drive_head) begin
      s_d.drive_q = io_wdata[DRIVE_SEL_BIT];
    end
    // decisions read registered values, so a write applies from the next access on
    // per-drive bits for the currently selected drive
    if (s_q.drive_q) begin
      fast_sel = s_q.master_q[FAST_SEL_DRV1_BIT];
      dma_only = s_q.master_q[DMA_ONLY_DRV1_BIT];
      ready_en = s_q.master_q[READY_EN_DRV1_BIT];
      pf_en = s_q.master_q[PREFETCH_DRV1_BIT];
    end else begin
      fast_sel = s_q.master_q[FAST_SEL_DRV0_BIT];
      dma_only = s_q.master_q[DMA_ONLY_DRV0_BIT];
      ready_en = s_q.master_q[READY_EN_DRV0_BIT];
      pf_en = s_q.master_q[PREFETCH_DRV0_BIT];
    end
    // slave values only when enabled and drive 1 is selected
    use_slave = s_q.master_q[SLAVE_REG_EN_BIT] && s_q.drive_q;
    if (use_slave) begin
      sp_code = s_q.slave_q[SLAVE_SAMPLE_LSB +: 2];
      rc_code = s_q.slave_q[SLAVE_RECOV_LSB +: 2];
    end else begin
      sp_code = s_q.master_q[MASTER_SAMPLE_LSB +: 2];
      rc_code = s_q.master_q[MASTER_RECOV_LSB +: 2];
    end
    // reads and writes share one prefetch/posting enable, so is_write needs no decode
    // decision latched on each access
    if (acc.valid) begin
      if (!acc.data_port) begin
        s_d.sel_q.path = PATH_COMPAT8;
      end else if (fast_sel && (acc.dma || !dma_only)) begin
        s_d.sel_q.path = PATH_FAST;
      end else begin
        s_d.sel_q.path = PATH_COMPAT16;
      end
      s_d.sel_q.prefetch_post = pf_en && acc.data_port;
      s_d.sel_q.sample_ready = ready_en;
      s_d.sel_q.sample_clks = enc_clks(SAMPLE_BASE_CLKS, sp_code);
      s_d.sel_q.recov_clks = enc_clks(RECOV_BASE_CLKS, rc_code);
    end
  end

  // state register; reset gives compatible timing everywhere
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q <= '{MASTER_TIMING_RST, SLAVE_TIMING_RST, 1'b0,
               '{PATH_COMPAT16, 1'b0, 1'b0, SAMPLE_BASE_CLKS, RECOV_BASE_CLKS}};
    end else begin
      s_q <= s_d;
    end
  end

  // forced-asserted ready when sampling is off for this access
  // the cable level passes only while the last access enabled sampling
  assign ready_int = s_q.sel_q.sample_ready ? ready_pin : 1'b1;
  assign sel = s_q.sel_q;
  assign drive_sel = s_q.drive_q;

  // read mux; unmapped offsets read zero
  // combinational, so the host sees a write from the next cycle on
  always_comb begin
    if (cfg_addr == MASTER_TIMING_OFS) begin
      cfg_rdata = s_q.master_q;
    end else if (cfg_addr == SLAVE_TIMING_OFS) begin
      cfg_rdata = {8'h00, s_q.slave_q};
    end else begin
      cfg_rdata = 16'h0000;
    end
  end

  // path selection, checked one cycle after the access is taken
  a_nondata_compat8: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && !acc.data_port |=> sel.path == PATH_COMPAT8)
    else $error("non-data access not on 8-bit path");
  a_drv0_fast_off: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && acc.data_port && !drive_sel && !s_q.master_q[FAST_SEL_DRV0_BIT]
    |=> sel.path == PATH_COMPAT16)
    else $error("drive0 fast off not compat16");
  a_drv0_fast_on: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && acc.data_port && !drive_sel && s_q.master_q[FAST_SEL_DRV0_BIT]
    && !s_q.master_q[DMA_ONLY_DRV0_BIT] |=> sel.path == PATH_FAST)
    else $error("drive0 fast on not fast");
  a_drv0_dma_only: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && acc.data_port && !drive_sel && s_q.master_q[DMA_ONLY_DRV0_BIT]
    |=> sel.path == (($past(acc.dma) && $past(s_q.master_q[FAST_SEL_DRV0_BIT]))
    ? PATH_FAST : PATH_COMPAT16))
    else $error("drive0 dma-only misapplied");
  a_drv1_path: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && acc.data_port && drive_sel && !acc.dma && s_q.master_q[DMA_ONLY_DRV1_BIT]
    |=> sel.path == PATH_COMPAT16)
    else $error("drive1 pio with dma-only went fast");
  a_drv1_fast_on: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && acc.data_port && drive_sel && s_q.master_q[FAST_SEL_DRV1_BIT]
    && !s_q.master_q[DMA_ONLY_DRV1_BIT] |=> sel.path == PATH_FAST)
    else $error("drive1 fast on not fast");
  a_dma_fast: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && acc.data_port && acc.dma && !drive_sel && s_q.master_q[FAST_SEL_DRV0_BIT]
    |=> sel.path == PATH_FAST)
    else $error("drive0 dma not fast");
  // per-access attributes
  a_prefetch_drv0: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && acc.data_port && !drive_sel |=>
    sel.prefetch_post == $past(s_q.master_q[PREFETCH_DRV0_BIT]))
    else $error("drive0 prefetch mismatch");
  a_prefetch_nondata: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && !acc.data_port |=> !sel.prefetch_post)
    else $error("prefetch set on a non-data access");
  // internal ready: forced when off, the cable level when on
  a_ready_forced: assert property (@(posedge sys_clk) disable iff (rst)
    !sel.sample_ready |-> ready_int)
    else $error("ready not forced");
  a_ready_follows: assert property (@(posedge sys_clk) disable iff (rst)
    sel.sample_ready |-> ready_int == ready_pin)
    else $error("ready not taken from the cable");
  // clock counts from the master or the slave register
  a_slave_ignored: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && !s_q.master_q[SLAVE_REG_EN_BIT] |=>
    sel.sample_clks == SAMPLE_BASE_CLKS - {1'b0, $past(s_q.master_q[MASTER_SAMPLE_LSB +: 2])})
    else $error("slave register used while disabled");
  a_slave_recov_off: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && !s_q.master_q[SLAVE_REG_EN_BIT] |=>
    sel.recov_clks == RECOV_BASE_CLKS - {1'b0, $past(s_q.master_q[MASTER_RECOV_LSB +: 2])})
    else $error("slave recovery used while disabled");
  a_slave_sample: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && drive_sel && s_q.master_q[SLAVE_REG_EN_BIT] |=>
    sel.sample_clks == SAMPLE_BASE_CLKS - {1'b0, $past(s_q.slave_q[SLAVE_SAMPLE_LSB +: 2])}
    && sel.recov_clks == RECOV_BASE_CLKS - {1'b0, $past(s_q.slave_q[SLAVE_RECOV_LSB +: 2])})
    else $error("slave timing wrong");
  a_master_recov: assert property (@(posedge sys_clk) disable iff (rst)
    acc.valid && !drive_sel |=>
    sel.recov_clks == RECOV_BASE_CLKS - {1'b0, $past(s_q.master_q[MASTER_RECOV_LSB +: 2])})
    else $error("master recovery not applied to drive0");
  // drive-select copy follows the snooped device/head write
  a_snoop_copy: assert property (@(posedge sys_clk) disable iff (rst)
    io_wr_drive_head |=> drive_sel == $past(io_wdata[DRIVE_SEL_BIT]))
    else $error("drive-select copy not taken");
  // main scenarios
  c_fast_access: cover property (@(posedge sys_clk) sel.path == PATH_FAST);
  c_compat8_access: cover property (@(posedge sys_clk) sel.path == PATH_COMPAT8);
  c_slave_used: cover property (@(posedge sys_clk)
    acc.valid && drive_sel && s_q.master_q[SLAVE_REG_EN_BIT]);
  c_ready_sampled: cover property (@(posedge sys_clk) sel.sample_ready && !ready_pin);
  c_dma_only_pio: cover property (@(posedge sys_clk)
    acc.valid && acc.data_port && !acc.dma && !drive_sel
    && s_q.master_q[DMA_ONLY_DRV0_BIT] && s_q.master_q[FAST_SEL_DRV0_BIT]);

endmodule

`default_nettype wire

/* tb/ide_drive_model.sv */
// drive-side model of the ready line on the cable
// assumes the bench raises stall to make the drive hold ready low
`timescale 1ns/100ps
`default_nettype none

module ide_drive_model (
  input wire logic stall,
  output logic ready_pin
);
  // the ready line has a pull-up, so a drive that is not stalling reads high
  assign ready_pin = !stall;
endmodule

`default_nettype wire

/* tb/test_ide_drive_timing_select.sv */
// self-checking bench for the per-drive timing selection block
// assumes one 100 MHz clock; inputs change 1 ns after the rising edge
`timescale 1ns/100ps
`default_nettype none

module test_ide_drive_timing_select;
  import drive_timing_pkg::*;
  logic sys_clk, rst, cfg_wr, io_wr_drive_head, ready_pin, ready_int, drive_sel, stall;
  logic [7:0] cfg_addr, io_wdata;
  logic [15:0] cfg_wdata, cfg_rdata;
  logic [1:0] cfg_be;
  access_req_t acc;
  timing_sel_t sel;
  int mismatches, check_count;

  ide_drive_timing_select dut_u (.sys_clk(sys_clk), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
    .io_wr_drive_head(io_wr_drive_head), .io_wdata(io_wdata), .acc(acc),
    .ready_pin(ready_pin), .sel(sel), .ready_int(ready_int), .drive_sel(drive_sel));
  ide_drive_model drive_u (.stall(stall), .ready_pin(ready_pin));

  // compare one value, four-state exact
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // single exit point for the run
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // one-cycle configuration write pulse
  task automatic cfg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk) #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_wdata = d;
    @(posedge sys_clk) #1;
    cfg_wr = 1'b0;
  endtask

  // program the master register, then snoop a device/head write
  task automatic setup(input logic [15:0] m, input logic drv);
    cfg_write(8'h40, m);
    io_wr_drive_head = 1'b1;
    io_wdata = {3'h0, drv, 4'h0};
    @(posedge sys_clk) #1;
    io_wr_drive_head = 1'b0;
  endtask

  // one access pulse; sel is settled 1 ns after the taking edge
  task automatic access(input logic dp, input logic dma);
    acc = '{valid: 1'b1, data_port: dp, dma: dma, is_write: 1'b0};
    @(posedge sys_clk) #1;
    acc = '0;
  endtask

  task automatic path_case(input logic [15:0] m, input logic drv, input logic dp,
                           input logic dma, input timing_path_t exp);
    setup(m, drv);
    access(dp, dma);
    check("path", 16'(sel.path), 16'(exp));
  endtask

  // free-running clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    #20000;
    mismatches++;
    final_report();
  end

  initial begin
    {rst, cfg_wr, io_wr_drive_head, stall} = 4'h8;
    cfg_addr = 8'h40;
    {io_wdata, cfg_wdata} = '0;
    cfg_be = 2'h3;
    acc = '0;
    repeat (3) @(posedge sys_clk);
    #1 rst = 1'b0;
    check("reset_clks", {10'h0, sel.sample_clks, sel.recov_clks}, 16'h002c);
    check("reset_path", 16'(sel.path), 16'(PATH_COMPAT16));
    check("reset_master", cfg_rdata, 16'h0000);
    cfg_write(8'h44, 16'h00a5);
    check("slave_rd", cfg_rdata, 16'h00a5);
    cfg_write(8'h48, 16'h1234);
    check("unmapped_rd", cfg_rdata, 16'h0000);
    path_case(16'h0000, 1'b0, 1'b1, 1'b0, PATH_COMPAT16);
    path_case(16'h0001, 1'b0, 1'b1, 1'b0, PATH_FAST);
    path_case(16'h0009, 1'b0, 1'b1, 1'b0, PATH_COMPAT16);
    path_case(16'h0009, 1'b0, 1'b1, 1'b1, PATH_FAST);
    path_case(16'h0011, 1'b0, 1'b0, 1'b0, PATH_COMPAT8);
    path_case(16'h0000, 1'b1, 1'b1, 1'b0, PATH_COMPAT16);
    path_case(16'h0010, 1'b1, 1'b1, 1'b0, PATH_FAST);
    path_case(16'h0090, 1'b1, 1'b1, 1'b0, PATH_COMPAT16);
    check("drive_sel", {15'h0, drive_sel}, 16'h0001);
    path_case(16'h0004, 1'b0, 1'b1, 1'b0, PATH_COMPAT16);
    check("prefetch_on", {15'h0, sel.prefetch_post}, 16'h0001);
    path_case(16'h0000, 1'b0, 1'b1, 1'b0, PATH_COMPAT16);
    check("prefetch_off", {15'h0, sel.prefetch_post}, 16'h0000);
    // the drive holds ready low; sampling off must hide it
    stall = 1'b1;
    #1 check("ready_forced", {15'h0, ready_int}, 16'h0001);
    path_case(16'h0002, 1'b0, 1'b1, 1'b0, PATH_COMPAT16);
    check("ready_en", {15'h0, sel.sample_ready}, 16'h0001);
    check("ready_low", {15'h0, ready_int}, 16'h0000);
    stall = 1'b0;
    #1 check("ready_high", {15'h0, ready_int}, 16'h0001);
    // every slave encoding, slave register enabled, drive 1 selected
    for (int i = 0; i < 4; i++) begin
      cfg_write(8'h44, 16'(i * 16'h0050));
      path_case(16'h4000, 1'b1, 1'b1, 1'b0, PATH_COMPAT16);
      check("slave_clks", {10'h0, sel.sample_clks, sel.recov_clks},
            {10'h0, 3'(5 - i), 3'(4 - i)});
    end
    path_case(16'h0000, 1'b1, 1'b1, 1'b0, PATH_COMPAT16);
    check("slave_off", {10'h0, sel.sample_clks, sel.recov_clks}, 16'h002c);
    path_case(16'h7300, 1'b0, 1'b1, 1'b0, PATH_COMPAT16);
    check("master_clks", {10'h0, sel.sample_clks, sel.recov_clks}, 16'h0011);
    // byte lanes: lane 0 alone on the master, lane 1 alone leaves the slave as it was
    check("master_rd", cfg_rdata, 16'h7300);
    cfg_be = 2'h1;
    cfg_write(8'h40, 16'hffff);
    check("master_lane0", cfg_rdata, 16'h73ff);
    cfg_be = 2'h2;
    cfg_write(8'h44, 16'h00ff);
    check("slave_lane1", cfg_rdata, 16'h00f0);
    cfg_be = 2'h3;
    // mid-run reset: registers, drive copy and decision back to defaults
    io_wr_drive_head = 1'b1;
    io_wdata = 8'h10;
    @(posedge sys_clk) #1;
    io_wr_drive_head = 1'b0;
    check("drive_before", {15'h0, drive_sel}, 16'h0001);
    cfg_addr = 8'h40;
    rst = 1'b1;
    #1 check("rst_master", cfg_rdata, 16'h0000);
    check("rst_drive", {15'h0, drive_sel}, 16'h0000);
    check("rst_clks", {10'h0, sel.sample_clks, sel.recov_clks}, 16'h002c);
    @(posedge sys_clk) #1;
    rst = 1'b0;
    path_case(16'h0001, 1'b0, 1'b1, 1'b0, PATH_FAST);
    final_report();
  end
endmodule

`default_nettype wire
